//--- hw/dpc_output_ctrl.sv
// top of the dac output power-up control block with apb status/control
`timescale 1ns/1ps
`default_nettype none
module dpc_output_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dpc_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  output wire logic sdo,
  input wire logic supply_stable,
  input wire logic supervisor_reset_in_n,
  input wire logic coding_select_pin,
  input wire logic zero_load_pin_n,
  input wire logic simultaneous_update_pin_n,
  output logic supply_detect_out,
  output logic amp_output_switch,
  output logic ground_clamp_switch,
  output logic local_gnd_comp_en,
  output wire logic [dpc_pkg::NCH-1:0][dpc_pkg::DATA_W-1:0] core_code,
  output wire logic [dpc_pkg::NCH-1:0][dpc_pkg::OFS_W-1:0] offset_trim,
  output wire logic [dpc_pkg::NCH-1:0][dpc_pkg::CG_W-1:0] coarse_gain,
  output wire logic [dpc_pkg::NCH-1:0][dpc_pkg::FG_W-1:0] fine_gain,
  input wire logic [dpc_pkg::IO_W-1:0] io_pin_i,
  output wire logic [dpc_pkg::IO_W-1:0] io_pin_o,
  output wire logic [dpc_pkg::IO_W-1:0] io_pin_oe
);
  import dpc_pkg::*;

  logic [FRAME_BITS-1:0] frame_word;
  logic frame_valid;
  logic [FRAME_BITS-1:0] tx_word_q, tx_word_d;
  logic tx_load_q, tx_load_d;
  logic [IO_W-1:0] io_level;
  logic [FN_W-1:0] func_q, func_d;
  logic force_clamp_q, force_clamp_d;

  dpc_serial_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .sclk(sclk),
    .sync_n(sync_n),
    .sdin(sdin),
    .tx_word(tx_word_q),
    .tx_load(tx_load_q),
    .sdo(sdo),
    .frame_word(frame_word),
    .frame_valid(frame_valid)
  );

  dpc_io_port #(.W(IO_W)) u_io (
    .pclk(pclk),
    .presetn(presetn),
    .dir(func_q[FN_DIR_LO +: IO_W]),
    .out_val(func_q[FN_OUT_LO +: IO_W]),
    .pin_i(io_pin_i),
    .pin_o(io_pin_o),
    .pin_oe(io_pin_oe),
    .level(io_level)
  );

  // frame decode
  logic [2:0] f_reg, f_adr;
  logic f_rd, wr_ok, data_wr;
  assign f_reg = frame_word[REG_HI:REG_LO];
  assign f_adr = frame_word[ADR_HI:ADR_LO];
  assign f_rd = frame_word[RW_BIT];
  dpc_pwr_e pwr_q, pwr_d;
  // serial writes while unpowered are ignored: the core registers are not alive yet
  assign wr_ok = frame_valid && !f_rd && pwr_q != PW_OFF;
  assign data_wr = wr_ok && f_reg == REG_DATA;

  // power-up / brownout sequencing
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic zero_load;
  logic clamp_d;

  always_comb begin
    pwr_d = pwr_q;
    settle_d = settle_q;
    zero_load = 1'b0;
    if (!supply_stable || !supervisor_reset_in_n) begin
      pwr_d = PW_OFF;
      settle_d = '0;
    end else begin
      unique case (pwr_q)
        PW_OFF: begin
          if (settle_q == SETTLE_W'(SETTLE_CYC - 1)) begin
            // power-on state follows the clear and update pins
            if (!zero_load_pin_n || !simultaneous_update_pin_n) begin
              zero_load = 1'b1;
              pwr_d = PW_DRIVE;
            end else begin
              pwr_d = PW_CLAMP;
            end
          end else begin
            settle_d = settle_q + SETTLE_W'(1);
          end
        end
        PW_CLAMP: begin
          if (data_wr) begin
            pwr_d = PW_DRIVE;
          end
        end
        PW_DRIVE: begin
          pwr_d = PW_DRIVE;
        end
      endcase
    end
    // decided from the next state so a fault clamps within one cycle
    clamp_d = pwr_d != PW_DRIVE || force_clamp_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= PW_OFF;
      settle_q <= '0;
      ground_clamp_switch <= 1'b1;
      amp_output_switch <= 1'b0;
      supply_detect_out <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      settle_q <= settle_d;
      ground_clamp_switch <= clamp_d;
      amp_output_switch <= !clamp_d;
      supply_detect_out <= supply_stable;
    end
  end

  // per-channel registers
  logic [NCH-1:0][DATA_W-1:0] dac_w;
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic hit;
    logic [DATA_W-1:0] in_q, in_d, dac_q, dac_d, core_q, core_d;
    logic [OFS_W-1:0] ofs_q, ofs_d;
    logic [CG_W-1:0] cg_q, cg_d;
    logic [FG_W-1:0] fg_q, fg_d;
    assign hit = f_adr == 3'(ch) || f_adr == ADR_ALL;
    always_comb begin
      in_d = in_q;
      dac_d = dac_q;
      ofs_d = ofs_q;
      cg_d = cg_q;
      fg_d = fg_q;
      if (zero_load) begin
        in_d = DAC_ZERO;
        dac_d = DAC_ZERO;
      end else begin
        if (data_wr && hit) begin
          in_d = frame_word[DATA_W-1:0];
        end
        if (wr_ok && hit && f_reg == REG_OFFSET) begin
          ofs_d = frame_word[OFS_W-1:0];
        end
        if (wr_ok && hit && f_reg == REG_COARSE) begin
          cg_d = frame_word[CG_W-1:0];
        end
        if (wr_ok && hit && f_reg == REG_FINE) begin
          fg_d = frame_word[FG_W-1:0];
        end
        // update pin held low makes the dac register transparent
        if (!simultaneous_update_pin_n) begin
          dac_d = in_d;
        end
      end
      core_d = coding_select_pin ? dac_d : dac_d ^ SIGN_FLIP;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        in_q <= DAC_ZERO;
        dac_q <= DAC_ZERO;
        core_q <= DAC_ZERO;
        ofs_q <= '0;
        cg_q <= '0;
        fg_q <= '0;
      end else begin
        in_q <= in_d;
        dac_q <= dac_d;
        core_q <= core_d;
        ofs_q <= ofs_d;
        cg_q <= cg_d;
        fg_q <= fg_d;
      end
    end
    assign dac_w[ch] = dac_q;
    assign core_code[ch] = core_q;
    assign offset_trim[ch] = ofs_q;
    assign coarse_gain[ch] = cg_q;
    assign fine_gain[ch] = fg_q;
  end

  // function register, serial readback and apb slave
  logic apb_setup, apb_acc, apb_hit;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, lgnd_d;
  logic [DATA_W-1:0] rb;

  always_comb begin
    apb_setup = psel && !penable;
    apb_acc = psel && penable && pready;
    func_d = func_q;
    force_clamp_d = force_clamp_q;
    if (apb_acc && pwrite && paddr == OFS_FUNC) begin
      func_d = pwdata[FN_W-1:0];
    end
    if (apb_acc && pwrite && paddr == OFS_CTRL) begin
      force_clamp_d = pwdata[CTRL_FORCE_CLAMP];
    end
    // serial write wins over a simultaneous apb write
    if (wr_ok && f_reg == REG_FUNC) begin
      func_d = frame_word[FN_W-1:0];
    end
    lgnd_d = func_d[FN_LGND];
    unique case (f_reg)
      REG_FUNC: rb = {{(DATA_W - FN_W - IO_W){1'b0}}, io_level, func_q};
      REG_DATA: rb = dac_w[f_adr[0]];
      REG_COARSE: rb = {{(DATA_W - CG_W){1'b0}}, coarse_gain[f_adr[0]]};
      REG_FINE: rb = {{(DATA_W - FG_W){1'b0}}, fine_gain[f_adr[0]]};
      REG_OFFSET: rb = {{(DATA_W - OFS_W){1'b0}}, offset_trim[f_adr[0]]};
      default: rb = DAC_ZERO;
    endcase
    tx_load_d = frame_valid && f_rd;
    tx_word_d = tx_load_d ? {frame_word[FRAME_BITS-1:DATA_W], rb} : tx_word_q;
    pready_d = apb_setup;
    apb_hit = paddr == OFS_STATUS || paddr == OFS_FUNC || paddr == OFS_DAC_A ||
              paddr == OFS_DAC_B || paddr == OFS_CTRL;
    pslverr_d = apb_setup && !apb_hit;
    prdata_d = prdata;
    if (apb_setup) begin
      prdata_d = '0;
      unique case (paddr)
        OFS_STATUS: begin
          prdata_d[ST_CLAMP] = ground_clamp_switch;
          prdata_d[ST_SUPPLY] = supply_detect_out;
          prdata_d[ST_SUPERVISOR] = supervisor_reset_in_n;
          prdata_d[ST_DRIVE] = pwr_q == PW_DRIVE;
          prdata_d[ST_IO_LO +: IO_W] = io_level;
        end
        OFS_FUNC: prdata_d[FN_W-1:0] = func_q;
        OFS_DAC_A: prdata_d[DATA_W-1:0] = dac_w[0];
        OFS_DAC_B: prdata_d[DATA_W-1:0] = dac_w[1];
        OFS_CTRL: prdata_d[CTRL_FORCE_CLAMP] = force_clamp_q;
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q <= FN_RESET;
      force_clamp_q <= 1'b0;
      local_gnd_comp_en <= 1'b0;
      tx_word_q <= '0;
      tx_load_q <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      func_q <= func_d;
      force_clamp_q <= force_clamp_d;
      local_gnd_comp_en <= lgnd_d;
      tx_word_q <= tx_word_d;
      tx_load_q <= tx_load_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  switch_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    ground_clamp_switch != amp_output_switch) else $error("clamp and amplifier switch both in same state");

  supply_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    !supply_stable |=> ground_clamp_switch && !pwr_q[2]) else $error("output not clamped on supply loss");

  supervisor_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    !supervisor_reset_in_n |=> ground_clamp_switch && !amp_output_switch) else $error("supervisor low left output driven");

  detect_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    supply_stable ##1 !supply_stable |=> !supply_detect_out && $past(supply_detect_out)) else $error("detector pin lags");

  release_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q == PW_CLAMP && data_wr && supply_stable && supervisor_reset_in_n && !force_clamp_q
    |=> amp_output_switch ##1 amp_output_switch || !supply_stable) else $error("valid write did not release clamp");

  hold_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q == PW_CLAMP && !(frame_valid && !f_rd && f_reg == REG_DATA) |=> ground_clamp_switch)
    else $error("clamp released without a data write");

  zero_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    zero_load |=> dac_w[0] == DAC_ZERO && dac_w[1] == DAC_ZERO && pwr_q == PW_DRIVE)
    else $error("power-up zero load missing");

  update_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q == PW_OFF && settle_q == SETTLE_W'(SETTLE_CYC - 1) && supply_stable && supervisor_reset_in_n
    && zero_load_pin_n && !simultaneous_update_pin_n |=> amp_output_switch) else $error("update pin ignored at power-up");

  coding_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> core_code[0] == ($past(coding_select_pin) ? dac_w[0] : dac_w[0] ^ SIGN_FLIP))
    else $error("output coding mismatch");
endmodule : dpc_output_ctrl
`default_nettype wire

//--- hw/dpc_pkg.sv
// shared constants and types for the dac output power-up control block
package dpc_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SUPPLY_SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = $clog2(SETTLE_CYC + 1);

  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int RW_BIT = 23;
  localparam int REG_HI = 21;
  localparam int REG_LO = 19;
  localparam int ADR_HI = 18;
  localparam int ADR_LO = 16;
  localparam int DATA_W = 16;
  localparam logic [2:0] REG_FUNC = 3'h0;
  localparam logic [2:0] REG_DATA = 3'h2;
  localparam logic [2:0] REG_COARSE = 3'h3;
  localparam logic [2:0] REG_FINE = 3'h4;
  localparam logic [2:0] REG_OFFSET = 3'h5;
  localparam logic [2:0] ADR_ALL = 3'h4;

  localparam int NCH = 2;
  localparam int IO_W = 2;
  localparam int OFS_W = 8;
  localparam int CG_W = 2;
  localparam int FG_W = 6;
  localparam int FN_W = 5;
  localparam int FN_LGND = 0;
  localparam int FN_DIR_LO = 1;
  localparam int FN_OUT_LO = 3;
  localparam logic [FN_W-1:0] FN_RESET = 5'h00;
  localparam logic [DATA_W-1:0] DAC_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] SIGN_FLIP = 16'h8000;

  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [APB_AW-1:0] OFS_FUNC = 8'h04;
  localparam logic [APB_AW-1:0] OFS_DAC_A = 8'h08;
  localparam logic [APB_AW-1:0] OFS_DAC_B = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h10;
  localparam int ST_CLAMP = 0;
  localparam int ST_SUPPLY = 1;
  localparam int ST_SUPERVISOR = 2;
  localparam int ST_DRIVE = 3;
  localparam int ST_IO_LO = 4;
  localparam int CTRL_FORCE_CLAMP = 0;

  typedef enum logic [2:0] {
    PW_OFF = 3'b001,
    PW_CLAMP = 3'b010,
    PW_DRIVE = 3'b100
  } dpc_pwr_e;
endpackage : dpc_pkg

//--- hw/dpc_serial_rx.sv
// serial frame receiver and readback shifter, pins sampled on pclk
`timescale 1ns/1ps
`default_nettype none
module dpc_serial_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic [dpc_pkg::FRAME_BITS-1:0] tx_word,
  input wire logic tx_load,
  output logic sdo,
  output logic [dpc_pkg::FRAME_BITS-1:0] frame_word,
  output logic frame_valid
);
  import dpc_pkg::*;

  logic sclk_q, sync_q;
  logic [FRAME_BITS-1:0] shift_q, shift_d, tx_q, tx_d, word_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic valid_d;

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    word_d = frame_word;
    valid_d = 1'b0;
    if (sync_q && !sync_n) begin
      cnt_d = '0;
    end else if (!sync_n && sclk_q && !sclk) begin
      shift_d = {shift_q[FRAME_BITS-2:0], sdin};
      if (cnt_q != '1) begin
        cnt_d = cnt_q + CNT_W'(1);
      end
    end
    // only exactly 24 bits make a frame; anything else is dropped
    if (!sync_q && sync_n && cnt_q == CNT_W'(FRAME_BITS)) begin
      word_d = shift_q;
      valid_d = 1'b1;
    end
    if (tx_load) begin
      tx_d = tx_word;
    end else if (!sync_n && !sclk_q && sclk) begin
      // shifted on rising edges so the host samples on falling ones
      tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // serial clock idles high; a low start would fake an edge after reset
      sclk_q <= 1'b1;
      sync_q <= 1'b1;
      shift_q <= '0;
      cnt_q <= '0;
      tx_q <= '0;
      frame_word <= '0;
      frame_valid <= 1'b0;
    end else begin
      sclk_q <= sclk;
      sync_q <= sync_n;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      frame_word <= word_d;
      frame_valid <= valid_d;
    end
  end

  assign sdo = tx_q[FRAME_BITS-1];
endmodule : dpc_serial_rx
`default_nettype wire

//--- hw/dpc_io_port.sv
// two-way digital i/o port with per-pin direction and readback
`timescale 1ns/1ps
`default_nettype none
module dpc_io_port #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] out_val,
  input wire logic [W-1:0] pin_i,
  output wire logic [W-1:0] pin_o,
  output wire logic [W-1:0] pin_oe,
  output wire logic [W-1:0] level
);
  for (genvar i = 0; i < W; i++) begin : g_pin
    logic o_q, oe_q, lvl_q, lvl_d;
    always_comb begin
      lvl_d = dir[i] ? out_val[i] : pin_i[i];
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        o_q <= 1'b0;
        oe_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        o_q <= out_val[i];
        oe_q <= dir[i];
        lvl_q <= lvl_d;
      end
    end
    assign pin_o[i] = o_q;
    assign pin_oe[i] = oe_q;
    assign level[i] = lvl_q;
  end
endmodule : dpc_io_port
`default_nettype wire

//--- verification/dpc_host_model.sv
// serial host model that sends frames into the block
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model (
  input wire logic pclk,
  input wire logic sdo,
  output logic sclk,
  output logic sync_n,
  output logic sdin
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  // clock idles high between frames; each level lasts h pclk cycles, h of 2 or more
  task automatic send(input logic [23:0] word, input int nbits, input int h, output logic [23:0] rx);
    rx = '0;
    sync_n <= 1'b0; // frame opens on sync low
    for (int i = nbits - 1; i >= 0; i--) begin
      repeat (h) @(posedge pclk);
      sdin <= word[i]; // msb first, valid at the falling clock
      sclk <= 1'b1;
      repeat (h) @(posedge pclk);
      rx = {rx[22:0], sdo}; // readback bit taken as the clock falls
      sclk <= 1'b0;
    end
    repeat (h) @(posedge pclk);
    sclk <= 1'b1;
    repeat (h) @(posedge pclk);
    sync_n <= 1'b1; // frame closes on sync high
    // released data line must not keep its last bit
    sdin <= ~sdin;
    repeat (4) @(posedge pclk);
  endtask : send
endmodule : dpc_host_model
`default_nettype wire

//--- verification/dpc_output_ctrl_test.sv
// self-checking bench for the dac output power-up control block
`timescale 1ns/1ps
`default_nettype none
module dpc_output_ctrl_test;
  import dpc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, sclk, sync_n, sdin, sdo;
  logic supply_stable = 1'b1, sup_n = 1'b1, coding = 1'b0, zero_n = 1'b1, upd_n = 1'b1;
  logic detect, amp_sw, clamp_sw, lgnd_en;
  logic [NCH-1:0][DATA_W-1:0] core_code;
  logic [NCH-1:0][OFS_W-1:0] offset_trim;
  logic [NCH-1:0][CG_W-1:0] coarse_gain;
  logic [NCH-1:0][FG_W-1:0] fine_gain;
  logic [IO_W-1:0] io_pin_i, io_pin_o, io_pin_oe, dir, ov;
  logic [IO_W-1:0] io_ext = '0;
  logic [15:0] d, m;
  logic [23:0] rxw;
  int bad_count = 0;
  int num_checks = 0;

  // pin level seen by both sides: driven value where enabled, else the outside level
  assign io_pin_i = (io_pin_oe & io_pin_o) | (~io_pin_oe & io_ext);
  always #50 pclk = ~pclk;

  dpc_host_model dpc_host_model_i (.pclk(pclk), .sdo(sdo), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));
  dpc_output_ctrl dpc_output_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo),
    .supply_stable(supply_stable), .supervisor_reset_in_n(sup_n), .coding_select_pin(coding),
    .zero_load_pin_n(zero_n), .simultaneous_update_pin_n(upd_n), .supply_detect_out(detect),
    .amp_output_switch(amp_sw), .ground_clamp_switch(clamp_sw), .local_gnd_comp_en(lgnd_en),
    .core_code(core_code), .offset_trim(offset_trim), .coarse_gain(coarse_gain),
    .fine_gain(fine_gain), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one apb transfer; no wait count assumed, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [23:0] frm(input logic [2:0] rg, input logic [2:0] ad, input logic [15:0] v);
    return {2'h0, rg, ad, v};
  endfunction : frm

  // host speed is random, prompt or slow
  task automatic tx(input logic [23:0] w, input int nb = 24);
    dpc_host_model_i.send(w, nb, 2 + $urandom_range(3), rxw);
    cyc(6);
  endtask : tx

  task automatic sw(input logic cl);
    chk("clamp", cl, clamp_sw);
    chk("amp", !cl, amp_sw);
  endtask : sw

  initial begin
    #2000000;
    bad_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(24420));
    io_ext <= 2'($urandom);
    cyc(6);
    sw(1'b1); // clamped in reset
    presetn <= 1'b1;
    cyc(20);
    sw(1'b1); // pins high keep the clamp
    chk("detect", 1, detect); // detector out
    apb(0, OFS_STATUS, 0);
    chk("status", {26'h0, io_ext, 4'h7}, rd); // inputs read back
    chk("st_err", 0, er);
    $display("test power-up done");

    tx(frm(REG_COARSE, 3'h0, 16'h0001));
    chk("cg_a", 1, coarse_gain[0]);
    d = 16'($urandom);
    tx(frm(REG_OFFSET, 3'h1, d));
    chk("ofs_b", d[7:0], offset_trim[1]);
    sw(1'b1); // non-data write keeps the clamp
    tx(frm(REG_DATA, 3'h0, d), 23);
    sw(1'b1); // short frame dropped
    tx(frm(REG_DATA, 3'h0, d));
    sw(1'b0); // first data write releases
    $display("test first write done");

    for (int g = 0; g < 3; g++) begin
      tx(frm(REG_COARSE, ADR_ALL, 16'(g)));
      chk("cg", {2{2'(g)}}, coarse_gain); // three ranges
    end
    tx(frm(REG_FINE, ADR_ALL, d));
    chk("fg", {2{d[5:0]}}, fine_gain); // fine trim
    $display("test gain done");

    tx(frm(REG_FUNC, 3'h0, 16'h0001));
    chk("lgnd", 1, lgnd_en); // enable bit set
    dir = 2'($urandom);
    ov = 2'($urandom);
    apb(1, OFS_FUNC, {27'h0, ov, dir, 1'b0});
    cyc(2);
    chk("lgnd", 0, lgnd_en); // enable bit clear
    chk("oe", dir, io_pin_oe); // direction per pin
    chk("out", ov & dir, io_pin_o & dir); // driven value
    apb(0, OFS_FUNC, 0);
    chk("func", {27'h0, ov, dir, 1'b0}, rd);
    apb(0, OFS_STATUS, 0);
    chk("io_rb", (dir & ov) | (~dir & io_ext), rd[5:4]);
    // a read request loads the answer; the following frame shifts it out
    tx({1'b1, 1'b0, REG_FUNC, 3'h0, 16'h0000});
    tx({1'b1, 1'b0, REG_DATA, 3'h1, 16'h0000});
    chk("sdo", {1'b1, 1'b0, REG_FUNC, 3'h0, 9'h000, (dir & ov) | (~dir & io_ext), ov, dir, 1'b0}, rxw);
    apb(0, 8'h14, 0);
    chk("slverr", 1, er);
    chk("unmapped", 0, rd);
    $display("test function done");

    apb(1, OFS_CTRL, 1);
    cyc(2);
    sw(1'b1); // forced clamp keeps switches apart
    apb(1, OFS_CTRL, 0);
    cyc(2);
    sw(1'b0);
    supply_stable <= 1'b0;
    cyc(3);
    sw(1'b1); // supply fault clamps
    chk("detect", 0, detect);
    supply_stable <= 1'b1;
    cyc(20);
    sw(1'b1); // pins high after fault
    $display("test fault done");

    // rows of the power-on table: coding, clear and update pins
    for (int k = 0; k < 3; k++) begin
      coding <= (k == 1);
      zero_n <= (k == 1);
      upd_n <= (k == 0);
      m = (k == 1) ? DAC_ZERO : SIGN_FLIP;
      sup_n <= 1'b0;
      cyc(3);
      sw(1'b1); // supervisor low clamps
      sup_n <= 1'b1;
      cyc(20);
      sw(1'b0);
      chk("code", {m, m}, core_code); // zero code per coding
    end
    zero_n <= 1'b1;
    cyc(2);
    d = 16'($urandom);
    tx(frm(REG_DATA, 3'h1, d));
    chk("code_b", d ^ SIGN_FLIP, core_code[1]); // twos complement
    $display("test power-on table done");
    give_verdict();
  end
endmodule : dpc_output_ctrl_test
`default_nettype wire
